// [rtl/rxsr_cs_compare.sv]
// Purpose: hold channel status and detect an unchanged repeat
// Assumes: cs_valid pulses once per received status block
// Notes:   the first block after reset has nothing to compare with
module rxsr_cs_compare import rxsr_pkg::*; (
  input  wire logic               ref_clk,  // core clock
  input  wire logic               rst,      // async reset, active high
  input  wire logic               cs_valid, // new block captured
  input  wire logic [CS_BITS-1:0] cs_bits,  // first bits of the block
  output logic      [CS_BITS-1:0] cs_held,  // last block seen
  output logic                    cs_same   // pulse: repeat equals prior
);
  logic have_prev;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_held   <= '0;
      have_prev <= 1'b0;
    end else if (cs_valid) begin
      cs_held   <= cs_bits;
      have_prev <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_same <= 1'b0;
    end else begin
      cs_same <= cs_valid && have_prev && (cs_bits == cs_held);
    end
  end
endmodule // rxsr_cs_compare

// [rtl/rxsr_pin_sync.sv]
// Purpose: three-stage synchroniser for pins from outside the clock
// Assumes: inputs are asynchronous to ref_clk
// Notes:   a change is taken once stages two and three agree
module rxsr_pin_sync import rxsr_pkg::*; #(
  parameter int W = 3
) (
  input  wire logic         ref_clk, // core clock
  input  wire logic         rst,     // async reset, active high
  input  wire logic [W-1:0] pin,     // raw pin levels
  output logic      [W-1:0] level    // filtered level
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  // ff1 feeds only ff2, so metastability stays in the chain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
    end else begin
      ff1 <= pin;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // accept a bit only when two samples agree, rejecting single glitches
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (ff2[i] == ff3[i]) begin
          level[i] <= ff3[i];
        end
      end
    end
  end
endmodule // rxsr_pin_sync

// [rtl/rxsr_pkg.sv]
// Purpose: shared constants for the receiver status readout block
// Assumes: 100 MHz core clock, register addresses as printed
// Notes:   all offsets, field positions and timings live here
package rxsr_pkg;

  // register addresses on the serial control port
  localparam logic [7:0] ADDR_EVT_FLAGS = 8'heb;
  localparam logic [7:0] ADDR_RATE_CS   = 8'hec;
  localparam logic [7:0] ADDR_SUBQ      = 8'hed;
  localparam int         ADDR_W         = 8;

  // register widths
  localparam int EVT_W    = 8;
  localparam int RCS_W    = 56;
  localparam int SUBQ_W   = 88;
  localparam int CS_BITS  = 48;
  localparam int SUBQ_BITS = 80;

  // interrupt_event_flags bit positions
  localparam int EVT_ERR_BIT    = 1;
  localparam int EVT_PCM_BIT    = 2;
  localparam int EVT_EMPH_BIT   = 3;
  localparam int EVT_PARITY_BIT = 4;
  localparam int EVT_RATE_BIT   = 5;
  localparam int EVT_CS_BIT     = 6;
  localparam int EVT_SUBQ_BIT   = 7;

  // rate_and_channel_status field positions
  localparam int RCS_ERR_BIT  = 1;
  localparam int RCS_PCM_BIT  = 2;
  localparam int RCS_RATE_LSB = 4;
  localparam int RCS_CS_LSB   = 8;

  // subcode_q_with_crc field positions
  localparam int SUBQ_CRC0_BIT = 0;
  localparam int SUBQ_CRC1_BIT = 1;
  localparam int SUBQ_DATA_LSB = 8;

  // rate codes with a fixed meaning
  localparam logic [2:0] RATE_OUT_OF_RANGE = 3'h0;
  localparam logic [2:0] RATE_RESET        = 3'h0;

  // event pulse width
  localparam int CLK_PERIOD_NS = 10;
  localparam int EVT_PULSE_NS  = 100;
  localparam int EVT_PULSE_CYC =
    (EVT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {RXSR_ADDR, RXSR_SHIFT} rxsr_ser_t;

  // sample rate in 100 Hz units; 0 means out of range or unused
  function automatic logic [15:0] rxsr_rate_hz100(input logic [2:0] code,
                                                   input logic       x4);
    logic [15:0] base;
    base = 16'h0000;
    case (code)
      3'h1:    base = 16'd320;
      3'h2:    base = 16'd441;
      3'h3:    base = 16'd480;
      3'h4:    base = 16'd640;
      3'h5:    base = 16'd882;
      3'h6:    base = 16'd960;
      default: base = 16'h0000;
    endcase
    return x4 ? {base[14:0], 1'b0} : base;
  endfunction

endpackage

// [rtl/rxsr_status.sv]
// Purpose: read-side status registers of a biphase audio receiver
// Assumes: receiver core signals are on ref_clk; control pins are async
// Notes:   registers read over a four-wire serial port, LSB first
//
// Overview of operation
// - status update flag, cleared by reading
// - error and non-PCM identical in both registers
// - error shows live fault or PLL unlock
// - non-PCM bit shows live detection
// - rate codes mean 32 to 96 kHz
// - crystal select shifts codes to 64-192 kHz
// - rate code, flags, status bits placed
// - only first 48 status bits readable
// - update flag when block repeats unchanged
// - CRC result readable with subcode word
// - CRC result on both low bits
// - CRC flag low means error
// - subcode register layout, 88 bits
// - event pin high level or pulse
// - subcode register reloads at event rise
// - level event stays until flags read
module rxsr_status import rxsr_pkg::*; (
  input  wire logic                 ref_clk,         // core clock
  input  wire logic                 rst,             // async reset
  // control port pins
  input  wire logic                 ctl_ce,          // chip enable pin
  input  wire logic                 ctl_clk,         // serial clock pin
  input  wire logic                 ctl_di,          // serial data in
  output logic                      ctl_do,          // serial data out
  output logic                      ctl_do_oe,       // data out enable
  // receiver core state
  input  wire logic                 rx_trans_err,    // transmission error
  input  wire logic                 pll_locked,      // PLL locked
  input  wire logic                 non_pcm_det,     // non-PCM stream
  input  wire logic                 emph_det,        // pre-emphasis set
  input  wire logic                 parity_err,      // parity error now
  input  wire logic                 rate_meas_valid, // new rate result
  input  wire logic [2:0]           rate_meas_code,  // measured code
  input  wire logic                 cs_valid,        // status block done
  input  wire logic [CS_BITS-1:0]   cs_bits,         // status bits 0..47
  input  wire logic                 subq_detect,     // subcode word ready
  input  wire logic [SUBQ_BITS-1:0] subq_word,       // subcode Q word
  input  wire logic                 subq_crc_ok,     // CRC good
  // configuration held elsewhere
  input  wire logic                 crystal_rate_select, // x4 crystal
  input  wire logic                 subq_event_select,   // subcode source
  input  wire logic                 rate_event_select,   // rate source
  input  wire logic                 cs_event_select,     // status source
  input  wire logic                 evt_level_mode,      // 1 level, 0 pulse
  // outputs
  output logic                      event_out,       // event pin
  output logic [15:0]               rate_hz100       // rate, 100 Hz units
);
  localparam logic [7:0] PULSE_LEN = 8'(EVT_PULSE_CYC);

  logic [2:0]           pins;
  logic                 s_ce;
  logic                 s_clk;
  logic                 s_di;
  logic                 prev_ce;
  logic                 prev_clk;
  rxsr_ser_t            ser_state;
  logic [ADDR_W-1:0]    addr;
  logic [SUBQ_W-1:0]    shift_q;
  logic                 rd_evt;
  logic                 load_rd;
  logic                 addr_ok;
  logic [2:0]           rate_code;
  logic                 rate_update_flag;
  logic                 chstat_update_flag;
  logic                 subq_load_flag;
  logic [CS_BITS-1:0]   cs_held;
  logic                 cs_same;
  logic [SUBQ_W-1:0]    subq_reg;
  logic                 rx_error_bit;
  logic                 non_pcm_bit;
  logic [EVT_W-1:0]     evt_word;
  logic [RCS_W-1:0]     rcs_word;
  logic                 trig;
  logic                 evt_level;
  logic [7:0]           pulse_cnt;
  logic                 next_event;

  rxsr_pin_sync #(
    .W       (3)
  ) i_rxsr_pin_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     ({ctl_ce, ctl_clk, ctl_di}),
    .level   (pins)
  );

  assign s_ce  = pins[2];
  assign s_clk = pins[1];
  assign s_di  = pins[0];

  rxsr_cs_compare i_rxsr_cs_compare (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .cs_valid (cs_valid),
    .cs_bits  (cs_bits),
    .cs_held  (cs_held),
    .cs_same  (cs_same)
  );

  assign rx_error_bit = rx_trans_err || !pll_locked;
  assign non_pcm_bit  = non_pcm_det;

  // interrupt_event_flags image; live bits reflect the read moment
  always_comb begin
    evt_word                 = '0;
    evt_word[EVT_ERR_BIT]    = rx_error_bit;
    evt_word[EVT_PCM_BIT]    = non_pcm_bit;
    evt_word[EVT_EMPH_BIT]   = emph_det;
    evt_word[EVT_PARITY_BIT] = parity_err;
    evt_word[EVT_RATE_BIT]   = rate_update_flag;
    evt_word[EVT_CS_BIT]     = chstat_update_flag;
    evt_word[EVT_SUBQ_BIT]   = subq_load_flag;
  end

  always_comb begin
    rcs_word                                     = '0;
    rcs_word[RCS_ERR_BIT]                        = rx_error_bit;
    rcs_word[RCS_PCM_BIT]                        = non_pcm_bit;
    rcs_word[RCS_RATE_LSB +: 3]                  = rate_code;
    rcs_word[RCS_CS_LSB +: CS_BITS]              = cs_held;
  end

  // edge history of the filtered pins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_ce  <= 1'b0;
      prev_clk <= 1'b0;
    end else begin
      prev_ce  <= s_ce;
      prev_clk <= s_clk;
    end
  end

  assign addr_ok = (addr == ADDR_EVT_FLAGS) || (addr == ADDR_RATE_CS) ||
                   (addr == ADDR_SUBQ);
  // a read starts when chip enable rises in the address phase
  assign load_rd = (ser_state == RXSR_ADDR) && s_ce && !prev_ce && addr_ok;
  assign rd_evt  = load_rd && (addr == ADDR_EVT_FLAGS);

  // serial port: address in while enable low, data out while high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ser_state <= RXSR_ADDR;
      addr      <= '0;
      shift_q   <= '0;
      ctl_do_oe <= 1'b0;
    end else begin
      case (ser_state)
        RXSR_ADDR: begin
          if (!s_ce && s_clk && !prev_clk) begin
            addr <= {s_di, addr[ADDR_W-1:1]};
          end
          if (load_rd) begin
            ser_state <= RXSR_SHIFT;
            ctl_do_oe <= 1'b1;
            if (addr == ADDR_EVT_FLAGS) begin
              shift_q <= SUBQ_W'(evt_word);
            end else if (addr == ADDR_RATE_CS) begin
              shift_q <= SUBQ_W'(rcs_word);
            end else begin
              shift_q <= subq_reg;
            end
          end else if (s_ce && !prev_ce) begin
            addr <= '0; // unmapped address: stay silent
          end
        end
        RXSR_SHIFT: begin
          if (!s_ce) begin
            ser_state <= RXSR_ADDR;
            ctl_do_oe <= 1'b0;
            addr      <= '0;
          end else if (!s_clk && prev_clk) begin
            shift_q <= {1'b0, shift_q[SUBQ_W-1:1]};
          end
        end
        default: begin
          ser_state <= RXSR_ADDR;
          ctl_do_oe <= 1'b0;
        end
      endcase
    end
  end

  assign ctl_do = shift_q[0];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate_code <= RATE_RESET;
    end else if (rate_meas_valid) begin
      rate_code <= rate_meas_code;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate_hz100 <= '0;
    end else begin
      rate_hz100 <= rxsr_rate_hz100(rate_code, crystal_rate_select);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate_update_flag   <= 1'b0;
      chstat_update_flag <= 1'b0;
      subq_load_flag     <= 1'b0;
    end else begin
      rate_update_flag   <= rate_meas_valid || (rate_update_flag && !rd_evt);
      chstat_update_flag <= cs_same || (chstat_update_flag && !rd_evt);
      subq_load_flag     <= subq_detect || (subq_load_flag && !rd_evt);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      subq_reg <= '0;
    end else if (subq_detect) begin
      subq_reg                <= '0;
      subq_reg[SUBQ_CRC0_BIT] <= subq_crc_ok;
      subq_reg[SUBQ_CRC1_BIT] <= subq_crc_ok;
      subq_reg[SUBQ_DATA_LSB +: SUBQ_BITS] <= subq_word;
    end
  end

  // any selected source raises the pin; unselected flags stay silent
  assign trig = (subq_event_select && subq_detect) ||
                (rate_event_select && rate_meas_valid) ||
                (cs_event_select && cs_same);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evt_level <= 1'b0;
    end else begin
      evt_level <= trig || (evt_level && !rd_evt);
    end
  end

  // pulse timer; a new trigger restarts it so the pin stays high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulse_cnt <= '0;
    end else if (trig) begin
      pulse_cnt <= PULSE_LEN;
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end
  end

  always_comb begin
    if (evt_level_mode) begin
      next_event = trig || (evt_level && !rd_evt);
    end else begin
      next_event = trig || (pulse_cnt > 8'h01);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_out <= 1'b0;
    end else begin
      event_out <= next_event;
    end
  end

  // checks on the register images and the event pin
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_cs_flag_set: assert property (cs_same |=> chstat_update_flag)
    else $error("status update flag not set on repeat");
  a_cs_flag_clr: assert property (
    rd_evt && !cs_same |=> !chstat_update_flag)
    else $error("status update flag not cleared by read");
  a_rate_flag_clr: assert property (
    rd_evt && !rate_meas_valid |=> !rate_update_flag)
    else $error("rate flag not cleared by read");
  a_rate_latch: assert property (rate_meas_valid |=>
    rate_update_flag && rate_code == $past(rate_meas_code))
    else $error("rate result not latched with flag");
  a_err_same: assert property (rd_evt |=>
    shift_q[EVT_ERR_BIT] == $past(rx_trans_err || !pll_locked) &&
    shift_q[EVT_PCM_BIT] == $past(non_pcm_det))
    else $error("error or non-PCM differs between registers");
  a_err_snap: assert property (load_rd && addr == ADDR_RATE_CS |=>
    shift_q[RCS_ERR_BIT] == $past(rx_trans_err || !pll_locked) &&
    shift_q[RCS_PCM_BIT] == $past(non_pcm_det))
    else $error("error or non-PCM not captured at read");
  a_rcs_fields: assert property (load_rd && addr == ADDR_RATE_CS |=>
    shift_q[RCS_RATE_LSB +: 3] == $past(rate_code) &&
    shift_q[RCS_CS_LSB +: CS_BITS] == $past(cs_held))
    else $error("rate or status fields misplaced");
  a_rate_decode: assert property (rate_code == 3'h1 |=>
    rate_hz100 == (crystal_rate_select ? 16'd640 : 16'd320))
    else $error("rate decode wrong for crystal select");
  a_subq_load: assert property (subq_detect |=>
    subq_reg[SUBQ_DATA_LSB +: SUBQ_BITS] == $past(subq_word) &&
    subq_reg[SUBQ_CRC0_BIT] == $past(subq_crc_ok) &&
    subq_reg[SUBQ_CRC1_BIT] == subq_reg[SUBQ_CRC0_BIT])
    else $error("subcode word or CRC not loaded");
  a_subq_rise: assert property (
    subq_event_select && subq_detect |=> event_out && subq_load_flag)
    else $error("event pin not raised with subcode load");
  a_level_hold: assert property (evt_level_mode && event_out && !rd_evt &&
    $stable(evt_level_mode) |=> event_out)
    else $error("level event dropped before read");
  a_pulse_len: assert property (!evt_level_mode && trig &&
    $stable(evt_level_mode) [*1] |=> event_out [*8])
    else $error("event pulse too short");

  // scenarios the bench is meant to reach; a serial read is slow
  c_cs_read: cover property (chstat_update_flag ##[1:50] rd_evt);
  c_subq_read: cover property (
    subq_detect ##[1:1000] (load_rd && addr == ADDR_SUBQ));
  c_set_clear: cover property (rd_evt && cs_same);
endmodule // rxsr_status

// [test/rxsr_host_model.sv]
// Purpose: microcontroller model on the four-wire serial control port
// Assumes: device pins pass a three-stage synchroniser on ref_clk
// Notes:   every pin level is held 8 core cycles, above the 5 needed
module rxsr_host_model (
  input  wire logic ref_clk,   // core clock of the device
  output logic      ctl_ce,    // chip enable, high = data phase
  output logic      ctl_clk,   // serial clock, idle low
  output logic      ctl_di,    // serial data to the device
  input  wire logic ctl_do,    // serial data from the device
  input  wire logic ctl_do_oe  // device drives ctl_do
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HOLD = 8;

  // idle pins: the serial clock stands still between frames
  initial begin
    ctl_ce  = 1'b0;
    ctl_clk = 1'b0;
    ctl_di  = 1'b0;
  end

  // pins change only just after a falling core edge
  task automatic hold();
    repeat (HOLD) @(negedge ref_clk);
  endtask

  // prompt readout
  // a full 88-bit read takes about 16 us, far inside the readout limit
  task automatic read_reg(input logic [7:0] addr, input int nbits,
                          output logic [87:0] data, output int oe_cnt);
    int i;
    data   = '0;
    oe_cnt = 0;
    for (i = 0; i < 8; i++) begin
      ctl_di = addr[i];
      hold();
      ctl_clk = 1'b1;
      hold();
      ctl_clk = 1'b0;
      hold();
    end
    // the line is no longer meaningful, so it shows the inverse
    ctl_di = ~ctl_di;
    ctl_ce = 1'b1;
    hold();
    for (i = 0; i < nbits; i++) begin
      if (i > 0) begin
        ctl_clk = 1'b1;
        hold();
        ctl_clk = 1'b0;
        hold();
      end
      data[i] = ctl_do;
      if (ctl_do_oe === 1'b1) oe_cnt++;
    end
    ctl_ce = 1'b0;
    hold();
  endtask
endmodule // rxsr_host_model

// [test/spdif_rx_status_readout_tb.sv]
// Purpose: self-checking bench for the receiver status readout
// Assumes: inputs change at the falling edge of ref_clk
// Notes:   all register reads go through the host model
module spdif_rx_status_readout_tb import rxsr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 ref_clk, rst, ctl_ce, ctl_clk, ctl_di;
  logic                 ctl_do, ctl_do_oe, event_out;
  logic                 rx_trans_err, pll_locked, non_pcm_det;
  logic                 emph_det, parity_err, rate_meas_valid;
  logic                 cs_valid, subq_detect, subq_crc_ok;
  logic                 crystal_rate_select, subq_event_select;
  logic                 rate_event_select, cs_event_select;
  logic                 evt_level_mode;
  logic [2:0]           rate_meas_code;
  logic [CS_BITS-1:0]   cs_bits;
  logic [SUBQ_BITS-1:0] subq_word;
  logic [15:0]          rate_hz100;
  logic [87:0]          rd;
  int                   oe_n, bad_count, checks;

  // nominal rates in 100 Hz units for codes 0 to 7
  localparam logic [15:0] HZ [8] = '{16'h0000, 16'h0140, 16'h01b9,
    16'h01e0, 16'h0280, 16'h0372, 16'h03c0, 16'h0000};
  localparam logic [47:0] CS_A = 48'h0123_4567_89ab;
  localparam logic [47:0] CS_B = 48'hfedc_ba98_7654;

  // free-running 100 MHz core clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  rxsr_status i_rxsr_status (.ref_clk(ref_clk), .rst(rst),
    .ctl_ce(ctl_ce), .ctl_clk(ctl_clk), .ctl_di(ctl_di),
    .ctl_do(ctl_do), .ctl_do_oe(ctl_do_oe),
    .rx_trans_err(rx_trans_err), .pll_locked(pll_locked),
    .non_pcm_det(non_pcm_det), .emph_det(emph_det),
    .parity_err(parity_err), .rate_meas_valid(rate_meas_valid),
    .rate_meas_code(rate_meas_code), .cs_valid(cs_valid),
    .cs_bits(cs_bits), .subq_detect(subq_detect),
    .subq_word(subq_word), .subq_crc_ok(subq_crc_ok),
    .crystal_rate_select(crystal_rate_select),
    .subq_event_select(subq_event_select),
    .rate_event_select(rate_event_select),
    .cs_event_select(cs_event_select),
    .evt_level_mode(evt_level_mode), .event_out(event_out),
    .rate_hz100(rate_hz100));

  rxsr_host_model i_rxsr_host_model (.ref_clk(ref_clk),
    .ctl_ce(ctl_ce), .ctl_clk(ctl_clk), .ctl_di(ctl_di),
    .ctl_do(ctl_do), .ctl_do_oe(ctl_do_oe));

  // compare one value, count it, report a mismatch at once
  task automatic chk(input logic [87:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // read a register; only mapped addresses may enable the data pin
  task automatic rd_reg(input logic [7:0] a, input int n);
    int e;
    i_rxsr_host_model.read_reg(a, n, rd, oe_n);
    e = (a inside {ADDR_EVT_FLAGS, ADDR_RATE_CS, ADDR_SUBQ}) ? n : 0;
    chk(88'(oe_n), 88'(e), "data enable");
  endtask

  task automatic t_reset();
    rd_reg(ADDR_EVT_FLAGS, 8);
    chk(rd, 88'h0, "flags after reset");
    chk(88'(rate_hz100), 88'h0, "rate after reset");
    $display("test reset done");
  endtask

  // every mix of fault, unlock and non-PCM, read from both registers
  task automatic t_live();
    int i;
    logic [7:0] e;
    for (i = 0; i < 8; i++) begin
      rx_trans_err = i[0];
      pll_locked   = ~i[1];
      non_pcm_det  = i[2];
      emph_det     = i[1];
      parity_err   = i[0];
      e = {3'h0, i[0], i[1], i[2], i[0] | i[1], 1'b0};
      rd_reg(ADDR_EVT_FLAGS, 8);
      chk(rd, 88'(e), "live flags");
      rd_reg(ADDR_RATE_CS, 8);
      chk(rd, 88'(e & 8'h06), "live copy");
    end
    {rx_trans_err, non_pcm_det, emph_det, parity_err} = 4'h0;
    pll_locked = 1'b1;
    $display("test live done");
  endtask

  task automatic t_unmapped();
    rd_reg(8'h55, 8);
    $display("test unmapped done");
  endtask

  // all eight codes at both crystal settings; flag seen set after each result
  task automatic t_rate();
    int x, c;
    for (x = 0; x < 2; x++) begin
      for (c = 0; c < 8; c++) begin
        crystal_rate_select = x[0];
        rate_meas_code = c[2:0];
        rate_meas_valid = 1'b1;
        @(negedge ref_clk);
        rate_meas_valid = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(88'(rate_hz100),
            88'(x ? {HZ[c][14:0], 1'b0} : HZ[c]), "rate");
        rd_reg(ADDR_RATE_CS, 8);
        chk(rd, 88'({1'b0, c[2:0], 4'h0}), "rate code");
        rd_reg(ADDR_EVT_FLAGS, 8);
        chk(rd, 88'h20, "rate flag");
      end
    end
    // rate result routed to the event pin
    rate_event_select = 1'b1;
    rate_meas_valid = 1'b1;
    @(negedge ref_clk);
    rate_meas_valid = 1'b0;
    rate_event_select = 1'b0;
    chk(88'(event_out), 88'h1, "rate event");
    rd_reg(ADDR_EVT_FLAGS, 8);
    chk(rd, 88'h20, "rate flag on event");
    rd_reg(ADDR_EVT_FLAGS, 8);
    chk(rd, 88'h0, "rate flag cleared");
    $display("test rate done");
  endtask

  task automatic send_cs(input logic [47:0] v);
    cs_bits = v;
    cs_valid = 1'b1;
    @(negedge ref_clk);
    cs_valid = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  // read on event
  // level event on unchanged repeats, status read when it rises
  task automatic t_chstat();
    evt_level_mode = 1'b1;
    cs_event_select = 1'b1;
    send_cs(CS_A);
    chk(88'(event_out), 88'h0, "first block");
    send_cs(CS_A);
    chk(88'(event_out), 88'h1, "repeat block");
    // no further block arrives before this read
    rd_reg(ADDR_RATE_CS, 56);
    chk(rd, 88'({CS_A, 8'h70}), "status bits");
    chk(88'(event_out), 88'h1, "level held");
    rd_reg(ADDR_EVT_FLAGS, 8);
    chk(rd, 88'h40, "status flag");
    chk(88'(event_out), 88'h0, "level dropped");
    rd_reg(ADDR_EVT_FLAGS, 8);
    chk(rd, 88'h0, "status flag cleared");
    send_cs(CS_B);
    chk(88'(event_out), 88'h0, "changed block");
    send_cs(CS_B);
    chk(88'(event_out), 88'h1, "second repeat");
    rd_reg(ADDR_EVT_FLAGS, 8);
    cs_event_select = 1'b0;
    $display("test chstat done");
  endtask

  // two words, good then bad CRC, event pin in pulse style
  task automatic t_subq();
    int k, n;
    logic w;
    evt_level_mode = 1'b0;
    // subcode load routed to the event pin
    subq_event_select = 1'b1;
    for (k = 0; k < 2; k++) begin
      w = (k == 0);
      subq_word = k ? 80'h0246_8ace_1357_9bdf_0f1e
                    : 80'h1122_3344_5566_7788_99aa;
      subq_crc_ok = w;
      subq_detect = 1'b1;
      @(negedge ref_clk);
      subq_detect = 1'b0;
      n = 0;
      repeat (20) begin
        if (event_out === 1'b1) n++;
        @(negedge ref_clk);
      end
      chk(88'(n), 88'(EVT_PULSE_CYC), "pulse width");
      rd_reg(ADDR_SUBQ, 88);
      chk(rd, {subq_word, 6'h00, w, w}, "subcode");
      rd_reg(ADDR_EVT_FLAGS, 8);
      chk(rd, 88'h80, "subcode flag");
    end
    $display("test subq done");
  endtask

  task automatic conclude();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog: the tests need about 23000 cycles
  initial begin
    repeat (80000) @(posedge ref_clk);
    bad_count++;
    $display("BAD t=%0t watchdog ran out", $time);
    conclude();
  end

  // main sequence: quiet inputs, reset, then each test in turn
  initial begin
    bad_count = 0;
    checks = 0;
    rst = 1'b1;
    {rx_trans_err, non_pcm_det, emph_det, parity_err} = 4'h0;
    pll_locked = 1'b1;
    {rate_meas_valid, cs_valid, subq_detect, subq_crc_ok} = 4'h0;
    {crystal_rate_select, subq_event_select} = 2'h0;
    {rate_event_select, cs_event_select, evt_level_mode} = 3'h0;
    rate_meas_code = 3'h0;
    cs_bits = '0;
    subq_word = '0;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    t_reset();
    t_live();
    t_unmapped();
    t_rate();
    t_chstat();
    t_subq();
    conclude();
  end
endmodule // spdif_rx_status_readout_tb
